// File: bench/dil_host_model.sv
`timescale 1ns/1ns
`include "dil_params.svh"
// ----------------------------------------
// host processor side of the interrupt link
// ----------------------------------------
module dil_host_model (
	input wire logic clk_in,
	output logic opcode_fetch_n_out,
	output logic io_select_n_out,
	output logic [7:0] bus_out
);
	// strobes idle high, bus starts arbitrary
	initial begin
		opcode_fetch_n_out = 1'h1;
		io_select_n_out = 1'h1;
		bus_out = 8'h5a;
	end
	// acknowledge: both strobes low for two clock cycles
	task ack();
		@(posedge clk_in);
		opcode_fetch_n_out <= 1'h0;
		io_select_n_out <= 1'h0;
		repeat (2) @(posedge clk_in);
		opcode_fetch_n_out <= 1'h1;
		io_select_n_out <= 1'h1;
		@(posedge clk_in);
	endtask
	// one opcode fetch; released bus shows the inverse byte
	task fetch(input logic [7:0] op);
		@(posedge clk_in);
		opcode_fetch_n_out <= 1'h0;
		bus_out <= op;
		repeat (2) @(posedge clk_in);
		opcode_fetch_n_out <= 1'h1;
		bus_out <= ~op;
		@(posedge clk_in);
	endtask
	// handler return: prefix fetch then return fetch
	task handler_return_opcode();
		fetch(`DIL_OP_PFX);
		fetch(`DIL_OP_RET);
	endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/1ns
`include "dil_params.svh"
`define CHK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("FAIL %s exp %h got %h", nm, e, g); \
	end \
end
module tb;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic clk_in = 1'h0;
	logic rst_n_in = 1'h0;
	dil_pkg::dil_axi_req_t req = '0;
	dil_pkg::dil_axi_rsp_t rsp;
	logic ready = 1'h0, ack_n = 1'h1, strobe = 1'h0, chain_in = 1'h1;
	logic [7:0] xbyte = 8'h00, data_out, hbus, data_bus, vec, mb, kb, ve;
	logic [15:0] count = 16'h0000, blen;
	logic data_oe_n, chain_out, int_n, breq_n, fetch_n, io_n, oe_q, a;
	logic [63:0] ent;
	logic [63:0] rq[$];
	logic [7:0] vq[$];
	int bad_count = 0, n_compared = 0, drives = 0, n0, lows;
	always #4 clk_in = ~clk_in;
	// shared data bus: device wins while it drives
	assign data_bus = data_oe_n ? hbus : data_out;
	dil_dma_irq #(.PULSE_DIV(4)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.axi_req_in(req), .axi_rsp_out(rsp), .ready_in(ready),
		.bus_ack_n_in(ack_n), .xfer_strobe_in(strobe),
		.xfer_byte_in(xbyte), .byte_count_in(count),
		.opcode_fetch_n_in(fetch_n), .io_select_n_in(io_n),
		.data_bus_in(data_bus), .data_out(data_out),
		.data_oe_n_out(data_oe_n), .chain_enable_in(chain_in),
		.chain_enable_out(chain_out), .int_n_out(int_n),
		.bus_request_n_out(breq_n));
	dil_host_model host (.clk_in(clk_in), .opcode_fetch_n_out(fetch_n),
		.io_select_n_out(io_n), .bus_out(hbus));
	// ----------------------------------------
	// result watcher and bus tasks
	// ----------------------------------------
	// compares read data and vectors against the oldest note
	always @(posedge clk_in) begin
		oe_q <= data_oe_n;
		if (rsp.rvalid && req.rready) begin
			ent = rq.pop_front();
			`CHK("rdata", ent[31:0], rsp.rdata & ent[63:32])
		end
		if (!data_oe_n && oe_q && rst_n_in) begin
			drives++;
			// a drive with no note can never match
			ve = (vq.size() > 0) ? vq.pop_front() : ~data_out;
			`CHK("vector", ve, data_out)
		end
	end
	task automatic wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [1:0] e = `DIL_RESP_OK);
		@(posedge clk_in);
		req.awvalid <= 1'h1;
		req.awaddr <= ad;
		req.wvalid <= 1'h1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'h1;
		forever begin
			@(posedge clk_in);
			if (rsp.awready) req.awvalid <= 1'h0;
			if (rsp.wready) req.wvalid <= 1'h0;
			if (rsp.bvalid) break;
		end
		`CHK("bresp", e, rsp.bresp)
		req.bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e,
		input logic [7:0] m = 8'hff, input logic [1:0] r = `DIL_RESP_OK);
		rq.push_back({24'h00_0000, m, 24'h00_0000, e});
		@(posedge clk_in);
		req.arvalid <= 1'h1;
		req.araddr <= ad;
		req.rready <= 1'h1;
		forever begin
			@(posedge clk_in);
			if (rsp.arready) req.arvalid <= 1'h0;
			if (rsp.rvalid) break;
		end
		`CHK("rresp", r, rsp.rresp)
		req.rready <= 1'h0;
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(`DIL_A_CMD, {24'h00_0000, c});
	endtask
	// one transferred byte with its count
	task automatic trig(input logic [7:0] b, input logic [15:0] c);
		@(posedge clk_in);
		xbyte <= b;
		count <= c;
		strobe <= 1'h1;
		@(posedge clk_in);
		strobe <= 1'h0;
		repeat (3) @(posedge clk_in);
	endtask
	task summarize();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		#200000;
		bad_count++;
		summarize();
	end
	initial begin
		void'($urandom(44007));
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'h1;
		`CHK("int_n", 1'h1, int_n)
		rd(`DIL_A_CTRL, 8'h00);
		rd(`DIL_A_STAT, 8'h00);
		rd(8'h20, 8'h00, 8'hff, `DIL_RESP_ERR);
		wr(8'h20, 32'h0000_00ff, `DIL_RESP_ERR);
		// plain ready leads to a bus request
		cmd(`DIL_CMD_EN_DMA);
		ready <= 1'h1;
		repeat (3) @(posedge clk_in);
		`CHK("bus_request_n_n", 1'h0, breq_n)
		ready <= 1'h0;
		cmd(`DIL_CMD_DIS_DMA);
		// ready interrupt, acknowledge, handler return
		vec = 8'($urandom);
		wr(`DIL_A_VEC, {24'h00_0000, vec});
		wr(`DIL_A_CTRL, 32'h0000_0004);
		cmd(`DIL_CMD_EN_INT);
		cmd(`DIL_CMD_EN_DMA);
		ready <= 1'h1;
		repeat (3) @(posedge clk_in);
		`CHK("int_n", 1'h0, int_n)
		`CHK("bus_request_n_n", 1'h1, breq_n)
		rd(`DIL_A_STAT, 8'h05, 8'h05);
		vq.push_back(vec);
		host.ack();
		`CHK("chain_out", 1'h0, chain_out)
		rd(`DIL_A_STAT, 8'h02, 8'h03);
		`CHK("bus_request_n_n", 1'h1, breq_n)
		host.handler_return_opcode();
		repeat (3) @(posedge clk_in);
		`CHK("chain_out", 1'h1, chain_out)
		`CHK("bus_request_n_n", 1'h0, breq_n)
		ready <= 1'h0;
		cmd(`DIL_CMD_DIS_DMA);
		cmd(`DIL_CMD_RST_INT);
		// end of block while bus master, without and with auto restart
		for (int i = 0; i < 2; i++) begin
			a = i[0];
			wr(`DIL_A_CTRL, a ? 32'h0000_0019 : 32'h0000_0009);
			blen = 16'($urandom);
			wr(`DIL_A_BLEN, {16'h0000, blen});
			cmd(`DIL_CMD_EN_INT);
			cmd(`DIL_CMD_EN_DMA);
			cmd(`DIL_CMD_FORCE);
			ack_n <= 1'h0;
			trig(8'h00, blen ^ 16'h0001);
			`CHK("int_n", 1'h1, int_n)
			trig(8'h00, blen);
			lows = 0;
			repeat (32) begin
				@(posedge clk_in);
				lows += int'(!int_n);
			end
			`CHK("pulses", 1'h1, logic'(lows > 6 && lows < 10))
			`CHK("bus_request_n_n", ~a, breq_n)
			ack_n <= 1'h1;
			repeat (2) @(posedge clk_in);
			`CHK("int_n", 1'h0, int_n)
			rd(`DIL_A_STAT, a ? 8'h00 : 8'h08, 8'h08);
			if (!a) begin
				vq.push_back((vec & 8'hf9) | 8'h04);
				host.ack();
				cmd(`DIL_CMD_HANDLER_RETURN_OPCODE);
				rd(`DIL_A_STAT, 8'h00, 8'h02);
			end
			cmd(`DIL_CMD_DIS_DMA);
			cmd(`DIL_CMD_RST_INT);
			`CHK("int_n", 1'h1, int_n)
		end
		// byte match under mask, then chain priority
		wr(`DIL_A_CTRL, 32'h0000_000a);
		mb = 8'($urandom);
		kb = 8'($urandom) & 8'h7f;
		wr(`DIL_A_MATCH, {24'h00_0000, mb});
		wr(`DIL_A_MASK, {24'h00_0000, kb});
		cmd(`DIL_CMD_EN_INT);
		trig(mb ^ 8'h80, 16'h0000);
		`CHK("int_n", 1'h1, int_n)
		trig(mb ^ (kb & 8'($urandom)), 16'h0000);
		`CHK("int_n", 1'h0, int_n)
		rd(`DIL_A_STAT, 8'h10, 8'h10);
		chain_in <= 1'h0;
		n0 = drives;
		host.ack();
		`CHK("drives", n0, drives)
		`CHK("chain_out", 1'h0, chain_out)
		chain_in <= 1'h1;
		vq.push_back((vec & 8'hf9) | 8'h02);
		host.ack();
		`CHK("vectors", n0 + 1, drives)
		cmd(`DIL_CMD_RST_INT);
		// continuous ready mode: only the first ready rise interrupts
		wr(`DIL_A_CTRL, 32'h0000_0024);
		cmd(`DIL_CMD_EN_INT);
		cmd(`DIL_CMD_EN_DMA);
		ready <= 1'h1;
		repeat (3) @(posedge clk_in);
		`CHK("int_n", 1'h0, int_n)
		vq.push_back(vec);
		host.ack();
		cmd(`DIL_CMD_HANDLER_RETURN_OPCODE);
		ready <= 1'h0;
		repeat (2) @(posedge clk_in);
		ready <= 1'h1;
		repeat (3) @(posedge clk_in);
		`CHK("int_n", 1'h1, int_n)
		`CHK("bus_request_n_n", 1'h0, breq_n)
		// status snapshot, clear status, interrupt disable
		cmd(`DIL_CMD_RD_STAT);
		rd(`DIL_A_SNAP, 8'he0);
		cmd(`DIL_CMD_CLR_STAT);
		rd(`DIL_A_STAT, 8'hc0, 8'he0);
		cmd(`DIL_CMD_DIS_DMA);
		ready <= 1'h0;
		cmd(`DIL_CMD_DIS_INT);
		wr(`DIL_A_CTRL, 32'h0000_0001);
		trig(8'h00, blen);
		`CHK("int_n", 1'h1, int_n)
		cmd(`DIL_CMD_EN_INT);
		`CHK("int_n", 1'h0, int_n)
		cmd(`DIL_CMD_RST_INT);
		summarize();
	end
endmodule

// File: core/dil_dma_irq.sv
`timescale 1ns/1ns
`include "dil_params.svh"
// Function
// - ready interrupt raised before any bus request
// - end-of-block when count equals block length
// - byte match under mask requests interrupt
// - release bus first, then assert interrupt
// - interrupt only pulses while bus master
// - auto restart: interrupt, no end status
// - acknowledged device drives its vector byte
// - vector may carry status bits
// - pending holds interrupt low until acknowledge
// - in-service blocks interrupts, chain, requests
// - in-service clears pending; cause re-pends
// - return opcode or control byte clears service
// - ready sets pending instead of requesting
// - ready to bus request within two cycles
// - continuous mode: only first ready interrupts
// - snoop return opcode, free chain output
// - return re-enables requests in ready mode
// - ready latch only with ready option
// - control bytes for interrupt and dma
// - claim only with chain input high
// - only highest chain member gives vector
module dil_dma_irq #(
	parameter int PULSE_DIV = `DIL_PULSE_DIV
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire dil_pkg::dil_axi_req_t axi_req_in,
	output dil_pkg::dil_axi_rsp_t axi_rsp_out,
	input wire logic ready_in,
	input wire logic bus_ack_n_in,
	input wire logic xfer_strobe_in,
	input wire logic [7:0] xfer_byte_in,
	input wire logic [15:0] byte_count_in,
	input wire logic opcode_fetch_n_in,
	input wire logic io_select_n_in,
	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_out,
	output logic data_oe_n_out,
	input wire logic chain_enable_in,
	output logic chain_enable_out,
	output logic int_n_out,
	output logic bus_request_n_out
);
	localparam logic [7:0] DIV_LAST = 8'(PULSE_DIV - 1);

	//----------------------------------------
	// helper functions
	//----------------------------------------
	// masked compare: mask ones are ignored
	function automatic logic byte_hit(input logic [7:0] d,
		input logic [7:0] m, input logic [7:0] k);
		byte_hit = ((d ^ m) & ~k) == 8'h00;
	endfunction

	// vector, optionally carrying status
	function automatic logic [7:0] vec_of(
		input dil_pkg::dil_state_t s);
		logic [1:0] c;
		c = s.st_eob ? `DIL_VC_EOB :
			s.st_match ? `DIL_VC_MATCH : `DIL_VC_RDY;
		if (s.ctrl[`DIL_C_SAV]) begin
			vec_of = {s.vec[7:3], c, s.vec[0]};
		end else begin
			vec_of = s.vec;
		end
	endfunction

	function automatic logic [7:0] stat_of(
		input dil_pkg::dil_state_t s);
		stat_of = {s.bus_request_n, s.dma_en, s.st_rdy, s.st_match,
			s.st_eob, s.ready_irq_latch, s.in_service_latch, s.pend};
	endfunction

	function automatic logic map_ok(input logic [7:0] a);
		map_ok = a == `DIL_A_CTRL || a == `DIL_A_VEC ||
			a == `DIL_A_MATCH || a == `DIL_A_MASK ||
			a == `DIL_A_BLEN || a == `DIL_A_CMD ||
			a == `DIL_A_STAT || a == `DIL_A_SNAP;
	endfunction

	function automatic logic [15:0] rd_of(
		input dil_pkg::dil_state_t s, input logic [7:0] a);
		unique case (a)
			`DIL_A_CTRL: rd_of = {8'h00, s.ctrl};
			`DIL_A_VEC: rd_of = {8'h00, s.vec};
			`DIL_A_MATCH: rd_of = {8'h00, s.mtch};
			`DIL_A_MASK: rd_of = {8'h00, s.mask};
			`DIL_A_BLEN: rd_of = s.blen;
			`DIL_A_STAT: rd_of = {8'h00, stat_of(s)};
			`DIL_A_SNAP: rd_of = {8'h00, s.snap};
			default: rd_of = 16'h0000;
		endcase
	endfunction

	//----------------------------------------
	// state and decoded events
	//----------------------------------------
	dil_pkg::dil_state_t st_r;
	dil_pkg::dil_state_t st_nxt;
	logic ack, fetch, ack_start, fetch_start, handler_return_opcode;
	logic rdy_act, rdy_rise, ior_set, eob_hit, match_hit;
	logic wr_go, cmd_go, want;
	logic c_rst_int, c_en_int, c_dis_int, c_en_dma;
	logic c_dis_dma, c_force, c_rd_stat, c_clr_stat, c_handler_return_opcode;

	// acknowledge is fetch and io strobe low together
	assign ack = !opcode_fetch_n_in && !io_select_n_in;
	assign fetch = !opcode_fetch_n_in && io_select_n_in;
	assign ack_start = ack && !st_r.ack_q;
	assign fetch_start = fetch && !st_r.fetch_q;
	// second opcode byte after the prefix byte
	assign handler_return_opcode = fetch_start && st_r.ret == dil_pkg::DIL_RT_PFX &&
		data_bus_in == `DIL_OP_RET;
	assign rdy_act = ready_in || st_r.force_rdy;
	assign rdy_rise = rdy_act && !st_r.rdy_q;
	// ready latch only with the option, once in continuous
	assign ior_set = rdy_rise && st_r.ctrl[`DIL_C_IOR] &&
		st_r.dma_en && st_r.int_en && !st_r.in_service_latch &&
		!st_r.ready_irq_latch && !st_r.ior_done;
	assign eob_hit = xfer_strobe_in && st_r.ctrl[`DIL_C_EOB] &&
		byte_count_in == st_r.blen;
	assign match_hit = xfer_strobe_in && st_r.ctrl[`DIL_C_MATCH] &&
		byte_hit(xfer_byte_in, st_r.mtch, st_r.mask);
	assign wr_go = st_r.aw_ok && st_r.w_ok;
	assign cmd_go = wr_go && st_r.aw_addr == `DIL_A_CMD &&
		st_r.w_strb[0];
	// control byte decode
	assign c_rst_int = cmd_go && st_r.w_data[7:0] == `DIL_CMD_RST_INT;
	assign c_en_int = cmd_go && st_r.w_data[7:0] == `DIL_CMD_EN_INT;
	assign c_dis_int = cmd_go && st_r.w_data[7:0] == `DIL_CMD_DIS_INT;
	assign c_en_dma = cmd_go && st_r.w_data[7:0] == `DIL_CMD_EN_DMA;
	assign c_dis_dma = cmd_go && st_r.w_data[7:0] == `DIL_CMD_DIS_DMA;
	assign c_force = cmd_go && st_r.w_data[7:0] == `DIL_CMD_FORCE;
	assign c_rd_stat = cmd_go && st_r.w_data[7:0] == `DIL_CMD_RD_STAT;
	assign c_clr_stat = cmd_go &&
		st_r.w_data[7:0] == `DIL_CMD_CLR_STAT;
	assign c_handler_return_opcode = cmd_go && st_r.w_data[7:0] == `DIL_CMD_HANDLER_RETURN_OPCODE;

	//----------------------------------------
	// next state
	//----------------------------------------
	always_comb begin
		st_nxt = st_r;
		want = 1'b0;
		st_nxt.ack_q = ack;
		st_nxt.fetch_q = fetch;
		st_nxt.rdy_q = rdy_act;
		// pulse divider for interrupt while bus master
		if (st_r.div == DIV_LAST) begin
			st_nxt.div = 8'h00;
			st_nxt.pulse = 1'b1;
		end else begin
			st_nxt.div = st_r.div + 8'h01;
			st_nxt.pulse = 1'b0;
		end
		// return opcode prefix tracking
		if (fetch_start) begin
			st_nxt.ret = (data_bus_in == `DIL_OP_PFX) ?
				dil_pkg::DIL_RT_PFX : dil_pkg::DIL_RT_IDLE;
		end
		// bus write channel capture
		if (axi_req_in.awvalid && axi_rsp_out.awready) begin
			st_nxt.aw_ok = 1'b1;
			st_nxt.aw_addr = axi_req_in.awaddr;
		end
		if (axi_req_in.wvalid && axi_rsp_out.wready) begin
			st_nxt.w_ok = 1'b1;
			st_nxt.w_data = axi_req_in.wdata[15:0];
			st_nxt.w_strb = axi_req_in.wstrb[1:0];
		end
		// register write and response
		if (wr_go) begin
			st_nxt.aw_ok = 1'b0;
			st_nxt.w_ok = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = map_ok(st_r.aw_addr) ?
				`DIL_RESP_OK : `DIL_RESP_ERR;
			if (st_r.w_strb[0]) begin
				unique case (st_r.aw_addr)
					`DIL_A_CTRL: st_nxt.ctrl = st_r.w_data[7:0];
					`DIL_A_VEC: st_nxt.vec = st_r.w_data[7:0];
					`DIL_A_MATCH: st_nxt.mtch = st_r.w_data[7:0];
					`DIL_A_MASK: st_nxt.mask = st_r.w_data[7:0];
					`DIL_A_BLEN: st_nxt.blen[7:0] = st_r.w_data[7:0];
					default: ;
				endcase
			end
			if (st_r.w_strb[1] && st_r.aw_addr == `DIL_A_BLEN) begin
				st_nxt.blen[15:8] = st_r.w_data[15:8];
			end
		end else if (st_r.bvalid && axi_req_in.bready) begin
			st_nxt.bvalid = 1'b0;
		end
		// read channel
		if (axi_req_in.arvalid && !st_r.rvalid) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_of(st_r, axi_req_in.araddr);
			st_nxt.rresp = map_ok(axi_req_in.araddr) ?
				`DIL_RESP_OK : `DIL_RESP_ERR;
		end else if (st_r.rvalid && axi_req_in.rready) begin
			st_nxt.rvalid = 1'b0;
		end
		// control bytes
		if (c_en_int) st_nxt.int_en = 1'b1;
		if (c_dis_int) st_nxt.int_en = 1'b0;
		if (c_en_dma) st_nxt.dma_en = 1'b1;
		if (c_force) st_nxt.force_rdy = 1'b1;
		if (c_rd_stat) st_nxt.snap = stat_of(st_r);
		if (c_dis_dma) begin
			st_nxt.dma_en = 1'b0;
			st_nxt.force_rdy = 1'b0;
			st_nxt.ior_done = 1'b0;
		end
		if (c_clr_stat || c_rst_int) begin
			st_nxt.st_eob = 1'b0;
			st_nxt.st_match = 1'b0;
			st_nxt.st_rdy = 1'b0;
			st_nxt.cause_eob = 1'b0;
			st_nxt.cause_match = 1'b0;
		end
		if (c_rst_int) begin
			st_nxt.int_en = 1'b0;
			st_nxt.pend = 1'b0;
			st_nxt.in_service_latch = 1'b0;
			st_nxt.ready_irq_latch = 1'b0;
		end
		// hardware causes, set wins over clear
		if (eob_hit) begin
			st_nxt.cause_eob = 1'b1;
			if (!st_r.ctrl[`DIL_C_AUTO]) begin
				st_nxt.st_eob = 1'b1;
				st_nxt.dma_en = 1'b0;
				st_nxt.force_rdy = 1'b0;
				st_nxt.ior_done = 1'b0;
			end
		end
		if (match_hit) begin
			st_nxt.cause_match = 1'b1;
			st_nxt.st_match = 1'b1;
			st_nxt.dma_en = 1'b0;
			st_nxt.force_rdy = 1'b0;
			st_nxt.ior_done = 1'b0;
		end
		if (ior_set) begin
			st_nxt.ready_irq_latch = 1'b1;
			st_nxt.st_rdy = 1'b1;
			if (st_r.ctrl[`DIL_C_CONT]) st_nxt.ior_done = 1'b1;
		end
		// return opcode or control byte ends service
		if ((handler_return_opcode && chain_enable_in && st_r.in_service_latch) || c_handler_return_opcode) begin
			st_nxt.in_service_latch = 1'b0;
			if (st_r.ctrl[`DIL_C_IOR] && st_nxt.dma_en) begin
				st_nxt.ready_irq_latch = 1'b0;
			end
		end
		// acknowledge: pending and chain high only
		if (ack_start && st_r.pend && chain_enable_in) begin
			st_nxt.in_service_latch = 1'b1;
			st_nxt.own = 1'b1;
			st_nxt.dout = vec_of(st_r);
		end
		if (!ack) st_nxt.own = 1'b0;
		// pending latch sets on any enabled live cause, cleared only by service or reset
		want = st_nxt.int_en && (st_nxt.ready_irq_latch ||
			st_nxt.cause_eob || st_nxt.cause_match);
		if (st_nxt.in_service_latch) begin
			st_nxt.pend = 1'b0;
		end else if (want) begin
			st_nxt.pend = 1'b1;
		end
		// bus request, blocked by service and ready latch
		st_nxt.bus_request_n = st_nxt.dma_en && !st_nxt.in_service_latch &&
			!st_nxt.ready_irq_latch && (rdy_act ||
			(st_r.bus_request_n && st_r.ctrl[`DIL_C_CONT]));
	end

	// state register, synchronous reset
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
			st_r.ret <= dil_pkg::DIL_RT_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	//----------------------------------------
	// outputs
	//----------------------------------------
	// bus slave handshakes
	assign axi_rsp_out.awready = !st_r.aw_ok && !st_r.bvalid;
	assign axi_rsp_out.wready = !st_r.w_ok && !st_r.bvalid;
	assign axi_rsp_out.bvalid = st_r.bvalid;
	assign axi_rsp_out.bresp = st_r.bresp;
	assign axi_rsp_out.arready = !st_r.rvalid;
	assign axi_rsp_out.rvalid = st_r.rvalid;
	assign axi_rsp_out.rdata = {16'h0000, st_r.rdata};
	assign axi_rsp_out.rresp = st_r.rresp;
	// interrupt low only off the bus, pulses while master
	assign int_n_out = !(st_r.pend &&
		(bus_ack_n_in || st_r.pulse));
	assign bus_request_n_out = !st_r.bus_request_n;
	assign chain_enable_out = chain_enable_in &&
		!st_r.pend && !st_r.in_service_latch;
	assign data_out = st_r.dout;
	assign data_oe_n_out = !st_r.own;

	//----------------------------------------
	// checks
	//----------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_ior_blocks;
		st_r.ready_irq_latch |-> !st_r.bus_request_n;
	endproperty
	a_ior_blocks: assert property (p_ior_blocks)
		else $error("bus request while ready latch set");

	property p_req_fast;
		(st_r.dma_en && ready_in && !st_r.ctrl[`DIL_C_IOR] &&
			!st_r.in_service_latch && !st_r.ready_irq_latch && !xfer_strobe_in &&
			!cmd_go && !ack_start) |-> ##[1:2] st_r.bus_request_n;
	endproperty
	a_req_fast: assert property (p_req_fast)
		else $error("bus request late after ready");

	property p_int_low;
		(st_r.pend && bus_ack_n_in) |-> !int_n_out;
	endproperty
	a_int_low: assert property (p_int_low)
		else $error("pending without interrupt low");

	property p_pulse_master;
		(!bus_ack_n_in && !st_r.pulse) |-> int_n_out;
	endproperty
	a_pulse_master: assert property (p_pulse_master)
		else $error("sustained interrupt while bus master");

	property p_ius_clr;
		$rose(st_r.in_service_latch) |-> !st_r.pend && $past(st_r.pend);
	endproperty
	a_ius_clr: assert property (p_ius_clr)
		else $error("service set without clearing pending");

	property p_ack_drive;
		(ack_start && st_r.pend && chain_enable_in) |=>
			(!data_oe_n_out && st_r.in_service_latch) [*1] ##0
			data_out == vec_of($past(st_r));
	endproperty
	a_ack_drive: assert property (p_ack_drive)
		else $error("vector not driven on acknowledge");

	property p_no_chain;
		(ack_start && !st_r.own && !chain_enable_in) |=>
			data_oe_n_out;
	endproperty
	a_no_chain: assert property (p_no_chain)
		else $error("vector driven with chain low");

	property p_chain_pass;
		(!chain_enable_in || st_r.in_service_latch) |-> !chain_enable_out;
	endproperty
	a_chain_pass: assert property (p_chain_pass)
		else $error("chain output high while blocked");

	property p_handler_return_opcode_clr;
		(handler_return_opcode && chain_enable_in && st_r.in_service_latch && !ack_start) |=>
			!st_r.in_service_latch;
	endproperty
	a_handler_return_opcode_clr: assert property (p_handler_return_opcode_clr)
		else $error("return opcode did not end service");

	property p_auto_eob;
		(eob_hit && st_r.ctrl[`DIL_C_AUTO] && !st_r.st_eob) |=>
			!st_r.st_eob;
	endproperty
	a_auto_eob: assert property (p_auto_eob)
		else $error("end status set under auto restart");

	property p_ior_opt;
		$rose(st_r.ready_irq_latch) |-> $past(st_r.ctrl[`DIL_C_IOR]);
	endproperty
	a_ior_opt: assert property (p_ior_opt)
		else $error("ready latch set without option");

	property p_match_cause;
		match_hit |=> st_r.st_match && !st_r.dma_en;
	endproperty
	a_match_cause: assert property (p_match_cause)
		else $error("byte match not recorded");
endmodule

// File: core/dil_params.svh
`ifndef DIL_PARAMS_SVH
`define DIL_PARAMS_SVH
// register byte addresses
`define DIL_A_CTRL 8'h00
`define DIL_A_VEC 8'h04
`define DIL_A_MATCH 8'h08
`define DIL_A_MASK 8'h0C
`define DIL_A_BLEN 8'h10
`define DIL_A_CMD 8'h14
`define DIL_A_STAT 8'h18
`define DIL_A_SNAP 8'h1C
// control register bit positions
`define DIL_C_EOB 0
`define DIL_C_MATCH 1
`define DIL_C_IOR 2
`define DIL_C_SAV 3
`define DIL_C_AUTO 4
`define DIL_C_CONT 5
// control byte codes
`define DIL_CMD_RST_INT 8'h01
`define DIL_CMD_EN_INT 8'h02
`define DIL_CMD_DIS_INT 8'h03
`define DIL_CMD_EN_DMA 8'h04
`define DIL_CMD_DIS_DMA 8'h05
`define DIL_CMD_FORCE 8'h06
`define DIL_CMD_RD_STAT 8'h07
`define DIL_CMD_CLR_STAT 8'h08
`define DIL_CMD_HANDLER_RETURN_OPCODE 8'h09
// handler return opcode bytes
`define DIL_OP_PFX 8'hED
`define DIL_OP_RET 8'h4D
// vector cause codes
`define DIL_VC_EOB 2'b10
`define DIL_VC_MATCH 2'b01
`define DIL_VC_RDY 2'b00
// bus responses and defaults
`define DIL_RESP_OK 2'b00
`define DIL_RESP_ERR 2'b10
`define DIL_PULSE_DIV 16
`endif

// File: core/dil_pkg.sv
package dil_pkg;
	typedef enum logic [1:0] {
		DIL_RT_IDLE = 2'b01,
		DIL_RT_PFX = 2'b10
	} dil_ret_t;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} dil_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dil_axi_rsp_t;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] vec;
		logic [7:0] mtch;
		logic [7:0] mask;
		logic [15:0] blen;
		logic [7:0] snap;
		logic dma_en;
		logic force_rdy;
		logic int_en;
		logic pend;
		logic in_service_latch;
		logic ready_irq_latch;
		logic ior_done;
		logic cause_eob;
		logic cause_match;
		logic st_eob;
		logic st_match;
		logic st_rdy;
		logic bus_request_n;
		logic rdy_q;
		logic ack_q;
		logic fetch_q;
		logic own;
		logic [7:0] dout;
		logic [7:0] div;
		logic pulse;
		dil_ret_t ret;
		logic aw_ok;
		logic [7:0] aw_addr;
		logic w_ok;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
	} dil_state_t;
endpackage
